// *** hw/dcf_consts.svh ***
// Purpose: Constants for the dual-flag buffer
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define DCF_WORD_W 9
`define DCF_DEPTH 8192
`define DCF_STAGE_DEPTH 16
`define DCF_OFS_W 8

// ----------------------------------------
// Offset register order and reset values
// ----------------------------------------
`define DCF_OFS_EMPTY_LOW 0
`define DCF_OFS_EMPTY_HIGH 1
`define DCF_OFS_FULL_LOW 2
`define DCF_OFS_FULL_HIGH 3
`define DCF_OFS_COUNT 4
`define DCF_OFS_RST_LOW 8'h07
`define DCF_OFS_RST_HIGH 8'h00

`endif

// *** hw/dcf_offset_regs.sv ***
// Purpose: Four flag offset registers with sequential access
// Assumes: Write and read are not used in the same cycle
// Notes: Access pointers survive load release
`timescale 1ns/1ns
`include "dcf_consts.svh"
module dcf_offset_regs
    import dcf_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    // Sequential access
    input wire logic wr_en_in,
    input wire logic [`DCF_OFS_W-1:0] wr_data_in,
    input wire logic rd_en_in,
    output logic [`DCF_OFS_W-1:0] rd_data_out,
    // Combined offsets
    output logic [2*`DCF_OFS_W-1:0] empty_ofs_out,
    output logic [2*`DCF_OFS_W-1:0] full_ofs_out
);
    logic [`DCF_OFS_W-1:0] ofs_r [`DCF_OFS_COUNT];
    dcf_sel_t wr_sel_r;
    dcf_sel_t rd_sel_r;

    // Rotate to the next register, wrapping
    function automatic dcf_sel_t next_sel(input dcf_sel_t s);
        dcf_sel_t n;
        n = dcf_sel_t'({s[2:0], s[3]});
        return n;
    endfunction : next_sel

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    for (genvar i = 0; i < `DCF_OFS_COUNT; i++) begin : g_ofs
        localparam logic [`DCF_OFS_W-1:0] RV = (i % 2 == 0) ?
            `DCF_OFS_RST_LOW : `DCF_OFS_RST_HIGH;
        always_ff @(posedge clock_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                ofs_r[i] <= RV;
            end else if (clear_in) begin
                ofs_r[i] <= RV;
            end else if (wr_en_in && wr_sel_r[i]) begin
                ofs_r[i] <= wr_data_in;
            end
        end
    end

    // ----------------------------------------
    // Access pointers
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_sel_r <= dcf_sel_empty_low;
            rd_sel_r <= dcf_sel_empty_low;
        end else if (clear_in) begin
            wr_sel_r <= dcf_sel_empty_low;
            rd_sel_r <= dcf_sel_empty_low;
        end else begin
            if (wr_en_in) begin
                wr_sel_r <= next_sel(wr_sel_r);
            end
            if (rd_en_in) begin
                rd_sel_r <= next_sel(rd_sel_r);
            end
        end
    end

    wire [1:0] rd_idx = {rd_sel_r[3] | rd_sel_r[2], rd_sel_r[3] | rd_sel_r[1]};
    assign rd_data_out = ofs_r[rd_idx];
    assign empty_ofs_out = {ofs_r[`DCF_OFS_EMPTY_HIGH],
                            ofs_r[`DCF_OFS_EMPTY_LOW]};
    assign full_ofs_out = {ofs_r[`DCF_OFS_FULL_HIGH],
                           ofs_r[`DCF_OFS_FULL_LOW]};

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    a_seq_order: assert property (
        !clear_in && wr_en_in && wr_sel_r == dcf_sel_empty_low
        ##1 !clear_in && wr_en_in |=> wr_sel_r == dcf_sel_full_low)
        else $error("offset write order broken");
    a_seq_wrap: assert property (
        !clear_in && wr_en_in && wr_sel_r == dcf_sel_full_high
        |=> wr_sel_r == dcf_sel_empty_low)
        else $error("offset write sequence did not wrap");
    a_seq_keep: assert property (
        !clear_in && !wr_en_in |=> $stable(wr_sel_r))
        else $error("offset position lost without a write");
endmodule : dcf_offset_regs

// *** hw/dcf_pkg.sv ***
// Purpose: Types for the dual-flag buffer
// Assumes: Nothing
// Notes: Constants live in dcf_consts.svh
package dcf_pkg;

    // Mode caught while the device reset pin is low
    typedef enum logic [1:0] {
        dcf_mode_prog = 2'b01,
        dcf_mode_dual = 2'b10
    } dcf_mode_t;

    // Offset register pointer, one-hot
    typedef enum logic [3:0] {
        dcf_sel_empty_low = 4'b0001,
        dcf_sel_empty_high = 4'b0010,
        dcf_sel_full_low = 4'b0100,
        dcf_sel_full_high = 4'b1000
    } dcf_sel_t;

endpackage : dcf_pkg

// *** hw/dcf_stage_fifo.sv ***
// Purpose: Small prefetch FIFO with valid and ready on both sides
// Assumes: One clock
// Notes: Push refused when full, pop refused when empty
`timescale 1ns/1ns
module dcf_stage_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    // Occupancy
    output logic [$clog2(DEPTH):0] level_out
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0] wp_r;
    logic [PW:0] rp_r;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;

    assign level_out = wp_r - rp_r;
    assign in_ready_out = (level_out != (PW+1)'(DEPTH));
    assign out_valid_out = (wp_r != rp_r);
    assign out_data_out = mem[rp_r[PW-1:0]];

    always_ff @(posedge clock_in) begin
        if (push) begin
            mem[wp_r[PW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp_r <= '0;
            rp_r <= '0;
        end else if (clear_in) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_r + (PW+1)'(push);
            rp_r <= rp_r + (PW+1)'(pop);
        end
    end
endmodule : dcf_stage_fifo

// *** hw/dcf_top.sv ***
// Purpose: Nine-bit buffer with empty, full and programmable flags
// Assumes: Write and read ports share clock_in; pins are synchronous
// Notes: Words pass the main array, then a prefetch stage, then out
`timescale 1ns/1ns
`include "dcf_consts.svh"
module dcf_top
    import dcf_pkg::*;
#(
    parameter int DEPTH = `DCF_DEPTH,
    parameter int STAGE_DEPTH = `DCF_STAGE_DEPTH
) (
    // Clock and system reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Device reset pin
    input wire logic fifo_reset_n_in,
    // Write port
    input wire logic [`DCF_WORD_W-1:0] write_data_in,
    input wire logic write_enable_primary_n_in,
    input wire logic write_enable_secondary_load_in,
    // Read port
    input wire logic read_enable_a_n_in,
    input wire logic read_enable_b_n_in,
    input wire logic output_enable_n_in,
    output logic [`DCF_WORD_W-1:0] read_data_out,
    output logic read_data_oe_out,
    // Flags
    output logic empty_flag_n_out,
    output logic full_flag_n_out,
    output logic almost_empty_flag_n_out,
    output logic almost_full_flag_n_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam int LW = $clog2(STAGE_DEPTH) + 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [`DCF_WORD_W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] arr_count_r;
    logic [CW-1:0] total_r;
    logic [`DCF_WORD_W-1:0] read_data_r;
    logic empty_flag_n_r;
    logic full_flag_n_r;
    logic almost_empty_flag_n_r;
    logic almost_full_flag_n_r;
    dcf_mode_t mode_r;

    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    wire run = fifo_reset_n_in;
    wire prog_mode = (mode_r == dcf_mode_prog);
    wire wen_primary = !write_enable_primary_n_in;
    wire load_low = prog_mode && !write_enable_secondary_load_in;
    wire ren_both = !read_enable_a_n_in && !read_enable_b_n_in;
    // Same pin level qualifies both modes: second enable or load high
    wire fifo_wr_req = wen_primary && write_enable_secondary_load_in;
    wire fifo_wr = run && fifo_wr_req && full_flag_n_r;
    wire ofs_wr = run && load_low && wen_primary;
    wire ofs_rd = run && load_low && ren_both;
    wire fifo_rd_req = ren_both && !load_low;
    wire pf_pop = run && fifo_rd_req && empty_flag_n_r;

    // ----------------------------------------
    // Array to prefetch stage
    // ----------------------------------------
    logic pf_in_ready;
    logic pf_out_valid;
    logic [`DCF_WORD_W-1:0] pf_out_data;
    logic [LW-1:0] pf_level;
    wire move = (arr_count_r != '0) && pf_in_ready;
    wire [`DCF_WORD_W-1:0] arr_head = mem[rd_ptr_r];

    dcf_stage_fifo #(
        .WIDTH(`DCF_WORD_W),
        .DEPTH(STAGE_DEPTH)
    ) u_stage (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .clear_in(!run),
        .in_valid_in(move),
        .in_ready_out(pf_in_ready),
        .in_data_in(arr_head),
        .out_valid_out(pf_out_valid),
        .out_ready_in(pf_pop),
        .out_data_out(pf_out_data),
        .level_out(pf_level)
    );

    // ----------------------------------------
    // Offset registers
    // ----------------------------------------
    logic [`DCF_OFS_W-1:0] ofs_rd_data;
    logic [2*`DCF_OFS_W-1:0] empty_ofs;
    logic [2*`DCF_OFS_W-1:0] full_ofs;

    dcf_offset_regs u_ofs (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .clear_in(!run),
        .wr_en_in(ofs_wr),
        .wr_data_in(write_data_in[`DCF_OFS_W-1:0]),
        .rd_en_in(ofs_rd),
        .rd_data_out(ofs_rd_data),
        .empty_ofs_out(empty_ofs),
        .full_ofs_out(full_ofs)
    );

    // ----------------------------------------
    // Counts and thresholds
    // ----------------------------------------
    wire [CW-1:0] n_thr = {1'b0, empty_ofs[AW-1:0]};
    wire [CW-1:0] m_thr = {1'b0, full_ofs[AW-1:0]};
    wire [CW-1:0] af_limit = DEPTH_C - m_thr;
    wire [CW-1:0] arr_count_nxt = arr_count_r + CW'(fifo_wr) - CW'(move);
    wire [CW-1:0] total_nxt = total_r + CW'(fifo_wr) - CW'(pf_pop);
    wire [LW-1:0] pf_level_nxt = pf_level + LW'(move) - LW'(pf_pop);
    wire empty_flag_n_nxt = (pf_level_nxt != '0);
    wire full_flag_n_nxt = (total_nxt != DEPTH_C);
    wire almost_empty_flag_n_nxt = (total_nxt > n_thr);
    wire almost_full_flag_n_nxt = (total_nxt < af_limit);

    // ----------------------------------------
    // Array write and pointers
    // ----------------------------------------
    always_ff @(posedge clock_in) begin
        if (fifo_wr) begin
            mem[wr_ptr_r] <= write_data_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            arr_count_r <= '0;
            total_r <= '0;
        end else if (!run) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            arr_count_r <= '0;
            total_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_r + AW'(fifo_wr);
            rd_ptr_r <= rd_ptr_r + AW'(move);
            arr_count_r <= arr_count_nxt;
            total_r <= total_nxt;
        end
    end

    // ----------------------------------------
    // Mode caught from the pin during reset
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_r <= dcf_mode_dual;
        end else if (!run) begin
            mode_r <= write_enable_secondary_load_in ?
                dcf_mode_dual : dcf_mode_prog;
        end
    end

    // ----------------------------------------
    // Flags, registered on the clock edge
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            empty_flag_n_r <= 1'b0;
            full_flag_n_r <= 1'b1;
            almost_empty_flag_n_r <= 1'b0;
            almost_full_flag_n_r <= 1'b1;
        end else if (!run) begin
            empty_flag_n_r <= 1'b0;
            full_flag_n_r <= 1'b1;
            almost_empty_flag_n_r <= 1'b0;
            almost_full_flag_n_r <= 1'b1;
        end else begin
            empty_flag_n_r <= empty_flag_n_nxt;
            full_flag_n_r <= full_flag_n_nxt;
            almost_empty_flag_n_r <= almost_empty_flag_n_nxt;
            almost_full_flag_n_r <= almost_full_flag_n_nxt;
        end
    end

    // ----------------------------------------
    // Output register
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            read_data_r <= '0;
        end else if (!run) begin
            read_data_r <= '0;
        end else if (ofs_rd) begin
            read_data_r <= {1'b0, ofs_rd_data};
        end else if (pf_pop) begin
            read_data_r <= pf_out_data;
        end
    end

    assign read_data_out = read_data_r;
    assign read_data_oe_out = !output_enable_n_in;
    assign empty_flag_n_out = empty_flag_n_r;
    assign full_flag_n_out = full_flag_n_r;
    assign almost_empty_flag_n_out = almost_empty_flag_n_r;
    assign almost_full_flag_n_out = almost_full_flag_n_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    a_reset_empty: assert property (
        !fifo_reset_n_in |=> !empty_flag_n_out && total_r == '0
            && full_flag_n_out)
        else $error("reset did not empty the buffer");
    a_reset_data_low: assert property (
        !fifo_reset_n_in ##1 fifo_reset_n_in |-> read_data_out == '0)
        else $error("data outputs not low after reset");
    a_reset_thresholds: assert property (
        !fifo_reset_n_in |=> n_thr == CW'(7) && m_thr == CW'(7))
        else $error("thresholds not seven after reset");
    a_full_blocks: assert property (
        run && !full_flag_n_out && fifo_wr_req ##1 run
        |-> $stable(wr_ptr_r) && total_r <= $past(total_r))
        else $error("write accepted while full");
    a_empty_keeps: assert property (
        run && !empty_flag_n_out && fifo_rd_req |=> $stable(read_data_out))
        else $error("output changed on read while empty");
    a_dual_write: assert property (
        run && mode_r == dcf_mode_dual && wen_primary
        && write_enable_secondary_load_in && full_flag_n_out && !pf_pop
        ##1 run |-> total_r == $past(total_r) + CW'(1))
        else $error("dual mode write not stored");
    a_almost_empty: assert property (
        run ##1 run |-> almost_empty_flag_n_out == ($past(total_nxt) >
            $past(n_thr)))
        else $error("almost empty flag wrong for count");
    a_almost_full: assert property (
        run && total_r >= af_limit ##1 run && $stable(total_r)
        && $stable(af_limit) |-> !almost_full_flag_n_out)
        else $error("almost full flag high near full");
    a_empty_read_ok: assert property (
        pf_pop |-> pf_out_valid)
        else $error("read taken with nothing in prefetch");
    a_full_level: assert property (
        run ##1 run && total_r == DEPTH_C |-> !full_flag_n_out)
        else $error("full flag high with all locations used");

    // ----------------------------------------
    // Checks on mode, flags and data holding
    // ----------------------------------------
    a_mode_dual: assert property (
        !fifo_reset_n_in && write_enable_secondary_load_in
        |=> mode_r == dcf_mode_dual)
        else $error("dual enable mode not caught at reset");
    a_mode_prog: assert property (
        !fifo_reset_n_in && !write_enable_secondary_load_in
        |=> mode_r == dcf_mode_prog)
        else $error("flag mode not caught at reset");
    a_dual_needs_both: assert property (
        run && mode_r == dcf_mode_dual && !write_enable_secondary_load_in
        ##1 run |-> $stable(wr_ptr_r))
        else $error("dual mode wrote without second enable");
    a_prog_write: assert property (
        run && prog_mode && wen_primary && write_enable_secondary_load_in
        && full_flag_n_out && !pf_pop ##1 run
        |-> total_r == $past(total_r) + CW'(1))
        else $error("flag mode write not stored");
    a_read_taken: assert property (
        run && fifo_rd_req && empty_flag_n_out && !fifo_wr ##1 run
        |-> total_r == $past(total_r) - CW'(1))
        else $error("read with data present not taken");
    a_empty_blocks: assert property (
        run && !empty_flag_n_out && !fifo_wr ##1 run |-> $stable(total_r))
        else $error("read taken while empty");
    a_empty_none: assert property (
        total_r == '0 |-> !empty_flag_n_out)
        else $error("empty flag high with nothing stored");
    a_full_match: assert property (
        full_flag_n_out == (total_r != DEPTH_C))
        else $error("full flag disagrees with count");
    a_aempty_high: assert property (
        run && total_r > n_thr ##1 run && $stable(total_r) && $stable(n_thr)
        |-> almost_empty_flag_n_out)
        else $error("almost empty flag low above threshold");
    a_afull_high: assert property (
        run && DEPTH_C - total_r > m_thr ##1 run && $stable(total_r)
        && $stable(m_thr) |-> almost_full_flag_n_out)
        else $error("almost full flag low with room left");
    a_load_no_fifo: assert property (
        run && load_low ##1 run |-> $stable(total_r))
        else $error("buffer count moved during offset access");
    a_offset_out: assert property (
        ofs_rd |=> read_data_out == {1'b0, $past(ofs_rd_data)})
        else $error("offset read not on data outputs");
    a_data_holds: assert property (
        run && !pf_pop && !ofs_rd ##1 run |-> $stable(read_data_out))
        else $error("data outputs changed without a read");
    a_reset_pointers: assert property (
        !fifo_reset_n_in |=> wr_ptr_r == '0 && rd_ptr_r == '0
            && arr_count_r == '0)
        else $error("reset left stale pointers");
    a_count_bound: assert property (
        total_r <= DEPTH_C)
        else $error("unread count above depth");
    a_total_split: assert property (
        total_r == arr_count_r + CW'(pf_level))
        else $error("count split between array and stage lost");
endmodule : dcf_top

// *** sim/dcf_partner.sv ***
// Purpose: Producer and consumer pins facing the buffer
// Assumes: Callers enter tasks 2 ns after a rising edge
// Notes: Released bus shows the inverse of its last driven word
`timescale 1ns/1ns
module dcf_partner (
    // Clock
    input wire logic clock_in,
    // Buffer outputs
    input wire logic [8:0] read_data_in,
    input wire logic read_data_oe_in,
    // Pins toward the buffer
    output logic [8:0] write_data_out,
    output logic write_enable_primary_n_out,
    output logic write_enable_secondary_load_out,
    output logic read_enable_a_n_out,
    output logic read_enable_b_n_out,
    // Resolved data bus
    output logic [8:0] bus_out
);
    logic [8:0] last_r = 9'h000;

    // Idle pin levels before the first request
    initial begin
        write_data_out = 9'h000;
        write_enable_primary_n_out = 1'b1;
        write_enable_secondary_load_out = 1'b1;
        read_enable_a_n_out = 1'b1;
        read_enable_b_n_out = 1'b1;
    end

    // Floating bus never repeats the last driven value
    always @(posedge clock_in) begin
        if (read_data_oe_in) begin
            last_r <= read_data_in;
        end
    end
    assign bus_out = read_data_oe_in ? read_data_in : ~last_r;

    task automatic wr(input logic [8:0] w);
        write_data_out = w;
        write_enable_primary_n_out = 1'b0;
        @(posedge clock_in);
        #2;
        write_enable_primary_n_out = 1'b1;
        write_data_out = ~w;
        // One idle edge before the next request
        @(posedge clock_in);
        #2;
    endtask : wr

    task automatic rd(input logic a_n, input logic b_n);
        read_enable_a_n_out = a_n;
        read_enable_b_n_out = b_n;
        @(posedge clock_in);
        #2;
        read_enable_a_n_out = 1'b1;
        read_enable_b_n_out = 1'b1;
        @(posedge clock_in);
        #2;
    endtask : rd

    task automatic lvl(input logic v);
        write_enable_secondary_load_out = v;
    endtask : lvl
endmodule : dcf_partner

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for the flagged buffer
// Assumes: DEPTH of 64, one clock for both ports
// Notes: Queue model predicts data and all four flags
`timescale 1ns/1ns
module tb_top;
    localparam int DEPTH = 64;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic fifo_reset_n = 1'b0;
    logic oe_n = 1'b0;
    logic [8:0] wdata, rdata, bus, last;
    logic wp_n, ws, ra_n, rb_n, roe, ef_n, ff_n, ae_n, af_n;
    int err_total = 0;
    int comparisons = 0;
    int cnt = 0;
    logic [7:0] ofs [4];
    logic [8:0] q [$];
    logic [31:0] lfsr = 32'h0000_a6d3;
    logic [8:0] ldv [5] = '{9'h043, 9'h000, 9'h00a, 9'h000, 9'h151};

    always #10 clock_in = ~clock_in;

    dcf_top #(.DEPTH(DEPTH), .STAGE_DEPTH(16)) i_dut (
        .clock_in(clock_in), .rst_n_in(rst_n_in),
        .fifo_reset_n_in(fifo_reset_n), .write_data_in(wdata),
        .write_enable_primary_n_in(wp_n),
        .write_enable_secondary_load_in(ws),
        .read_enable_a_n_in(ra_n), .read_enable_b_n_in(rb_n),
        .output_enable_n_in(oe_n), .read_data_out(rdata),
        .read_data_oe_out(roe), .empty_flag_n_out(ef_n),
        .full_flag_n_out(ff_n), .almost_empty_flag_n_out(ae_n),
        .almost_full_flag_n_out(af_n));

    dcf_partner i_prt (
        .clock_in(clock_in), .read_data_in(rdata),
        .read_data_oe_in(roe), .write_data_out(wdata),
        .write_enable_primary_n_out(wp_n),
        .write_enable_secondary_load_out(ws),
        .read_enable_a_n_out(ra_n), .read_enable_b_n_out(rb_n),
        .bus_out(bus));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic chk(input logic [8:0] got, input logic [8:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic flags;
        int n;
        int m;
        n = int'({ofs[1], ofs[0]}) & (DEPTH - 1);
        m = int'({ofs[3], ofs[2]}) & (DEPTH - 1);
        repeat (4) @(posedge clock_in);
        #2;
        chk(9'(ef_n), 9'(cnt != 0), "empty");
        chk(9'(ff_n), 9'(cnt < DEPTH), "full");
        chk(9'(ae_n), 9'(cnt > n), "aempty");
        chk(9'(af_n), 9'(cnt < DEPTH - m), "afull");
    endtask : flags

    task automatic dev_reset(input logic dual);
        i_prt.lvl(dual);
        fifo_reset_n = 1'b0;
        repeat (2) @(posedge clock_in);
        #2;
        fifo_reset_n = 1'b1;
        @(posedge clock_in);
        #2;
        cnt = 0;
        q.delete();
        ofs = '{8'h07, 8'h00, 8'h07, 8'h00};
        chk(rdata, 9'h000, "reset data");
        flags();
    endtask : dev_reset

    task automatic fill(input int upto);
        logic [8:0] w;
        while (cnt < upto) begin
            lfsr = lfsr_next(lfsr);
            w = lfsr[8:0];
            i_prt.wr(w);
            q.push_back(w);
            cnt++;
            flags();
        end
    endtask : fill

    task automatic drain;
        while (cnt > 0) begin
            i_prt.rd(1'b0, 1'b0);
            last = q.pop_front();
            chk(bus, last, "read data");
            cnt--;
            flags();
        end
    endtask : drain

    task automatic wrap_up;
        $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        #200000;
        err_total++;
        $display("ERROR %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge clock_in);
        #2;
        rst_n_in = 1'b1;
        dev_reset(1'b1);
        fill(1);
        i_prt.rd(1'b0, 1'b1);
        i_prt.rd(1'b1, 1'b0);
        i_prt.lvl(1'b0);
        i_prt.wr(9'h155);
        i_prt.lvl(1'b1);
        flags();
        fill(DEPTH);
        i_prt.wr(9'h1aa);
        flags();
        drain();
        i_prt.rd(1'b0, 1'b0);
        chk(rdata, last, "held data");
        oe_n = 1'b1;
        #1;
        chk(9'(roe), 9'h000, "oe off");
        chk(bus, ~rdata, "bus floated");
        @(posedge clock_in);
        #2;
        oe_n = 1'b0;
        #1;
        chk(9'(roe), 9'h001, "oe on");
        chk(bus, rdata, "bus driven");
        @(posedge clock_in);
        #2;
        dev_reset(1'b0);
        foreach (ldv[k]) begin
            i_prt.wr(ldv[k]);
            ofs[k % 4] = ldv[k][7:0];
        end
        i_prt.lvl(1'b1);
        @(posedge clock_in);
        #2;
        i_prt.lvl(1'b0);
        i_prt.wr(9'h005);
        ofs[1] = 8'h05;
        for (int k = 0; k < 4; k++) begin
            i_prt.rd(1'b0, 1'b0);
            chk(rdata, {1'b0, ofs[k]}, "offset read");
        end
        i_prt.lvl(1'b1);
        flags();
        fill(DEPTH);
        drain();
        wrap_up();
    end
endmodule : tb_top
